// ### src/ddrci_regs.svh
// constant definitions for the ddr controller configuration core
`ifndef DDRCI_REGS_SVH
`define DDRCI_REGS_SVH
`define DDRCI_NUM_CS 4
`define DDRCI_ADDR_W 32
`define DDRCI_RC_W 4
`define DDRCI_TIM_W 5
`define DDRCI_MA_W 16
`define DDRCI_BA_W 3
`define DDRCI_ROW_BASE 12
`define DDRCI_COL_BASE 8
`define DDRCI_SPACE_LSB 24
`define DDRCI_AP_BIT 10
`define DDRCI_INIT_PRE 4'h1
`define DDRCI_INIT_MRS 4'h2
`define DDRCI_INIT_REF 4'h3
`endif

// ### src/ddrci_pkg.sv
// types for the ddr controller configuration core
package ddrci_pkg;
  typedef enum logic [2:0] {
    DDRCI_CMD_NOP,
    DDRCI_CMD_ACT,
    DDRCI_CMD_RD,
    DDRCI_CMD_WR,
    DDRCI_CMD_PRE,
    DDRCI_CMD_REF,
    DDRCI_CMD_MRS
  } ddrci_cmd_t;
endpackage

// ### src/ddrci_ctrl.sv
// chip select decode, address mux, init sequence and command spacing
`timescale 1ns/1ps
`include "ddrci_regs.svh"
module ddrci_ctrl #(
  parameter int NCS = `DDRCI_NUM_CS,
  parameter int TW = `DDRCI_TIM_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // configuration
  input wire logic mem_enable_in,
  input wire logic init_bypass_in,
  input wire logic dll_reset_skip_in,
  input wire logic two_cycle_command_timing_in,
  input wire logic [NCS-1:0] cs_enable_in,
  input wire logic [NCS-1:0] cs_auto_precharge_enable_in,
  input wire logic [NCS*8-1:0] cs_start_in,
  input wire logic [NCS*8-1:0] cs_end_in,
  input wire logic [NCS*`DDRCI_RC_W-1:0] cs_row_bits_in,
  input wire logic [NCS*`DDRCI_RC_W-1:0] cs_col_bits_in,
  input wire logic [TW-1:0] burst_to_precharge_interval_in,
  input wire logic [TW-1:0] precharge_to_activate_delay_in,
  input wire logic [TW-1:0] activate_to_rw_delay_in,
  input wire logic [TW-1:0] activate_to_activate_delay_in,
  input wire logic [TW-1:0] refresh_recovery_time_in,
  input wire logic [TW-1:0] write_to_read_delay_in,
  input wire logic [TW-1:0] additive_latency_in,
  input wire logic [TW-1:0] read_to_precharge_delay_in,
  // access request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [`DDRCI_ADDR_W-1:0] req_addr_in,
  input wire ddrci_pkg::ddrci_cmd_t req_cmd_in,
  // status and memory side
  output logic req_ready_out,
  output logic init_done_out,
  output logic dll_reset_out,
  output logic [NCS-1:0] mem_chip_select_n_out,
  output logic [`DDRCI_MA_W-1:0] mem_addr_out,
  output ddrci_pkg::ddrci_cmd_t mem_cmd_out
);
  import ddrci_pkg::*;

  // ==========================================================
  // chip select decode and address mux
  logic [NCS-1:0] hit;
  logic [NCS-1:0] hit_ap;
  logic [`DDRCI_MA_W-1:0] row_a [NCS];
  logic [`DDRCI_MA_W-1:0] col_a [NCS];
  logic [7:0] space;
  assign space = req_addr_in[`DDRCI_ADDR_W-1:`DDRCI_SPACE_LSB];
  genvar g;
  generate
    for (g = 0; g < NCS; g++) begin : g_cs
      logic [`DDRCI_RC_W-1:0] rb;
      logic [`DDRCI_RC_W-1:0] cb;
      logic [`DDRCI_ADDR_W-1:0] sh;
      assign rb = cs_row_bits_in[g*`DDRCI_RC_W +: `DDRCI_RC_W];
      assign cb = cs_col_bits_in[g*`DDRCI_RC_W +: `DDRCI_RC_W];
      assign hit[g] = cs_enable_in[g] && space >= cs_start_in[g*8 +: 8]
          && space <= cs_end_in[g*8 +: 8];
      // row sits above the column bits, both masked to their widths
      assign sh = req_addr_in >> (`DDRCI_COL_BASE + 32'(cb));
      assign row_a[g] = sh[`DDRCI_MA_W-1:0]
          & ((`DDRCI_MA_W'(1) << (`DDRCI_ROW_BASE + 32'(rb)))
          - `DDRCI_MA_W'(1));
      assign col_a[g] = req_addr_in[`DDRCI_MA_W-1:0]
          & ((`DDRCI_MA_W'(1) << (`DDRCI_COL_BASE + 32'(cb)))
          - `DDRCI_MA_W'(1));
      assign hit_ap[g] = hit[g] && cs_auto_precharge_enable_in[g];
    end
  endgenerate

  logic [`DDRCI_MA_W-1:0] sel_row;
  logic [`DDRCI_MA_W-1:0] sel_col;
  always_comb begin
    sel_row = '0;
    sel_col = '0;
    for (int i = NCS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        sel_row = row_a[i];
        sel_col = col_a[i];
      end
    end
  end

  logic auto_pre;
  assign auto_pre = (burst_to_precharge_interval_in == '0)
      || (|hit_ap);

  // ==========================================================
  // init sequence
  typedef enum logic [2:0] {
    DDRCI_IDLE, DDRCI_PRE, DDRCI_MRS, DDRCI_REF, DDRCI_RUN
  } ddrci_st_t;
  ddrci_st_t st_ff;
  logic issue;
  logic hold_ff;
  logic [TW-1:0] gap_ff;
  logic [TW-1:0] nxt_gap;
  ddrci_cmd_t nxt_cmd;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_ff <= DDRCI_IDLE;
    end else begin
      case (st_ff)
        DDRCI_IDLE: if (mem_enable_in) begin
          st_ff <= init_bypass_in ? DDRCI_RUN : DDRCI_PRE;
        end
        DDRCI_PRE: if (issue) begin
          st_ff <= DDRCI_MRS;
        end
        DDRCI_MRS: if (issue) begin
          st_ff <= DDRCI_REF;
        end
        DDRCI_REF: if (issue) begin
          st_ff <= DDRCI_RUN;
        end
        DDRCI_RUN: if (!mem_enable_in) begin
          st_ff <= DDRCI_IDLE;
        end
        default: st_ff <= DDRCI_IDLE;
      endcase
    end
  end

  // ==========================================================
  // command selection and spacing
  logic user_go;
  assign user_go = st_ff == DDRCI_RUN && req_valid_in && (|hit);
  assign issue = gap_ff == '0 && !hold_ff
      && (st_ff == DDRCI_PRE || st_ff == DDRCI_MRS
      || st_ff == DDRCI_REF || user_go);

  always_comb begin
    nxt_cmd = DDRCI_CMD_NOP;
    nxt_gap = '0;
    case (st_ff)
      DDRCI_PRE: begin
        nxt_cmd = DDRCI_CMD_PRE;
        nxt_gap = precharge_to_activate_delay_in;
      end
      DDRCI_MRS: begin
        nxt_cmd = DDRCI_CMD_MRS;
        nxt_gap = TW'(`DDRCI_INIT_MRS);
      end
      DDRCI_REF: begin
        nxt_cmd = DDRCI_CMD_REF;
        nxt_gap = refresh_recovery_time_in;
      end
      DDRCI_RUN: begin
        nxt_cmd = req_cmd_in;
        case (req_cmd_in)
          DDRCI_CMD_ACT: nxt_gap = activate_to_rw_delay_in
              > activate_to_activate_delay_in ? activate_to_rw_delay_in
              : activate_to_activate_delay_in;
          DDRCI_CMD_PRE: nxt_gap = precharge_to_activate_delay_in;
          DDRCI_CMD_REF: nxt_gap = refresh_recovery_time_in;
          DDRCI_CMD_WR: nxt_gap = write_to_read_delay_in;
          DDRCI_CMD_RD: nxt_gap = TW'(additive_latency_in
              + read_to_precharge_delay_in);
          default: nxt_gap = '0;
        endcase
      end
      default: nxt_cmd = DDRCI_CMD_NOP;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      gap_ff <= '0;
    end else if (issue) begin
      gap_ff <= nxt_gap;
    end else if (gap_ff != '0) begin
      gap_ff <= gap_ff - TW'(1);
    end
  end

  // two cycle mode keeps the command on the pins one extra cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= issue && two_cycle_command_timing_in;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      mem_cmd_out <= DDRCI_CMD_NOP;
      mem_chip_select_n_out <= '1;
      mem_addr_out <= '0;
    end else if (issue) begin
      mem_cmd_out <= nxt_cmd;
      mem_chip_select_n_out <= st_ff == DDRCI_RUN ? ~hit : '0;
      if (nxt_cmd == DDRCI_CMD_ACT) begin
        mem_addr_out <= sel_row;
      end else if (nxt_cmd == DDRCI_CMD_RD || nxt_cmd == DDRCI_CMD_WR) begin
        mem_addr_out <= sel_col | (auto_pre ? `DDRCI_MA_W'(1)
            << `DDRCI_AP_BIT : '0);
      end else begin
        mem_addr_out <= sel_col;
      end
    end else if (!hold_ff) begin
      mem_cmd_out <= DDRCI_CMD_NOP;
      mem_chip_select_n_out <= '1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      dll_reset_out <= 1'b0;
      init_done_out <= 1'b0;
      req_ready_out <= 1'b0;
    end else begin
      dll_reset_out <= issue && st_ff == DDRCI_MRS
          && !dll_reset_skip_in;
      init_done_out <= st_ff == DDRCI_RUN;
      req_ready_out <= user_go && issue;
    end
  end

  // ==========================================================
  // checks
  // a zero spacing field legally allows back to back commands
  spacing_a: assert property (@(posedge mclk_in)
      disable iff (srst_in) issue && nxt_gap != '0 |=> !issue)
    else $error("commands issued back to back");
  bypass_a: assert property (@(posedge mclk_in)
      disable iff (srst_in) st_ff == DDRCI_IDLE && mem_enable_in
      && init_bypass_in |=> st_ff == DDRCI_RUN)
    else $error("bypass did not skip init");
  init_a: assert property (@(posedge mclk_in)
      disable iff (srst_in) st_ff == DDRCI_IDLE && mem_enable_in
      && !init_bypass_in |=> st_ff == DDRCI_PRE)
    else $error("init not started");
  ap_a: assert property (@(posedge mclk_in)
      disable iff (srst_in) issue && st_ff == DDRCI_RUN && auto_pre
      && (nxt_cmd == DDRCI_CMD_RD || nxt_cmd == DDRCI_CMD_WR)
      |=> mem_addr_out[`DDRCI_AP_BIT])
    else $error("auto precharge bit missing");
  cs_hit_a: assert property (@(posedge mclk_in)
      disable iff (srst_in) issue && st_ff == DDRCI_RUN
      |=> mem_chip_select_n_out == ~$past(hit))
    else $error("wrong chip select");
  // first cycle shows the new command, second cycle repeats it
  sequence cmd_held_s;
    mem_cmd_out == $past(nxt_cmd) ##1 $stable(mem_cmd_out);
  endsequence
  two_t_a: assert property (@(posedge mclk_in)
      disable iff (srst_in) issue && two_cycle_command_timing_in
      |=> cmd_held_s)
    else $error("command not held two cycles");
  dll_a: assert property (@(posedge mclk_in)
      disable iff (srst_in) dll_reset_skip_in && $stable(dll_reset_skip_in)
      |=> !dll_reset_out)
    else $error("dll reset despite skip");
  row_a_a: assert property (@(posedge mclk_in)
      disable iff (srst_in) issue && nxt_cmd == DDRCI_CMD_ACT
      |=> mem_addr_out == $past(sel_row))
    else $error("row address wrong");
endmodule

// ### verification/ddrci_mem_model.sv
// behavioural memory device that logs the commands it is given
`timescale 1ns/1ps
module ddrci_mem_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // command pins
  input wire logic [3:0] mem_chip_select_n_in,
  input wire ddrci_pkg::ddrci_cmd_t mem_cmd_in,
  // log for the bench
  output logic [8:0] hist_out,
  output logic [7:0] cmd_count_out
);
  import ddrci_pkg::*;
  // ==========================================
  // command log
  // a device only sees a command while it is selected
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      hist_out <= 9'h000;
      cmd_count_out <= 8'h00;
    end else if (mem_cmd_in != DDRCI_CMD_NOP
        && !(&mem_chip_select_n_in)) begin
      hist_out <= {hist_out[5:0], mem_cmd_in};
      cmd_count_out <= cmd_count_out + 8'h01;
    end
  end
endmodule

// ### verification/ddr_controller_init_config_test.sv
// self-checking bench for the ddr controller configuration core
`timescale 1ns/1ps
`include "ddrci_regs.svh"
`define CHK(n, e, a) \
  cmp_count++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("ERROR %s expected %0h seen %0h", n, e, a); \
  end
module ddr_controller_init_config_test;
  import ddrci_pkg::*;
  // ==========================================
  // signals
  localparam int WAIT_CYC = 20000;
  localparam logic [8:0] INIT_SEQ = {DDRCI_CMD_PRE, DDRCI_CMD_MRS,
      DDRCI_CMD_REF};
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic mem_enable_in = 1'b0;
  logic init_bypass_in, dll_reset_skip_in, two_cycle_command_timing_in;
  logic req_valid_in, req_write_in, req_ready_out, init_done_out;
  logic dll_reset_out;
  logic [3:0] cs_enable_in, cs_auto_precharge_enable_in;
  logic [3:0] mem_chip_select_n_out;
  logic [31:0] cs_start_in, cs_end_in, req_addr_in;
  logic [15:0] cs_row_bits_in, cs_col_bits_in, mem_addr_out;
  logic [4:0] burst_to_precharge_interval_in, precharge_to_activate_delay_in;
  logic [4:0] activate_to_rw_delay_in, activate_to_activate_delay_in;
  logic [4:0] refresh_recovery_time_in, write_to_read_delay_in;
  logic [4:0] additive_latency_in, read_to_precharge_delay_in;
  ddrci_cmd_t req_cmd_in, mem_cmd_out;
  logic [8:0] hist;
  logic [7:0] ncmd;
  int fails = 0;
  int cmp_count = 0;
  always #5 mclk_in = ~mclk_in;
  ddrci_ctrl dut (.*);
  ddrci_mem_model mem (.mclk_in(mclk_in), .srst_in(srst_in),
    .mem_chip_select_n_in(mem_chip_select_n_out),
    .mem_cmd_in(mem_cmd_out), .hist_out(hist), .cmd_count_out(ncmd));
  // ==========================================
  // tasks
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic program_cfg(input logic [4:0] trp);
    // no port here for these boot fields; ddr1 values in brackets
    // termination selects (000), powerdown exit (0001)
    // ddr2 write termination 001, io termination on reads
    // write latency (001), column latency code
    // clock enable pulse (001), activate window (00001)
    // registered dimm bit, 8-beat bursts, strobe cfg 00
    // controller io termination (00)
    cs_enable_in = 4'hF;
    cs_start_in = 32'h03020100;
    cs_end_in = 32'h03020100;
    cs_row_bits_in = 16'h0000;
    cs_col_bits_in = 16'h0000;
    burst_to_precharge_interval_in = 5'h08;
    precharge_to_activate_delay_in = trp;
    activate_to_rw_delay_in = 5'h04;
    activate_to_activate_delay_in = 5'h06;
    refresh_recovery_time_in = trp + 5'h02;
    write_to_read_delay_in = 5'h02;
    additive_latency_in = 5'h01;
    read_to_precharge_delay_in = 5'h02;
    cs_auto_precharge_enable_in = 4'h0;
    two_cycle_command_timing_in = 1'b0;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_addr_in = 32'h0;
    req_cmd_in = DDRCI_CMD_NOP;
  endtask
  task automatic init_run(input logic skip, input logic byp,
                          input logic [4:0] trp);
    logic dll_seen;
    int i;
    dll_seen = 1'b0;
    srst_in = 1'b1;
    mem_enable_in = 1'b0;
    dll_reset_skip_in = skip;
    init_bypass_in = byp;
    program_cfg(trp);
    repeat (5) @(negedge mclk_in);
    srst_in = 1'b0;
    repeat (WAIT_CYC) @(negedge mclk_in);
    mem_enable_in = 1'b1;
    for (i = 0; i < 300 && init_done_out !== 1'b1; i++) begin
      @(negedge mclk_in);
      if (dll_reset_out === 1'b1) dll_seen = 1'b1;
    end
    `CHK("init_done", 1'b1, init_done_out)
    if (init_done_out !== 1'b1) finish_test();
    if (byp) begin
      `CHK("bypass cmds", 8'h00, ncmd)
    end else begin
      `CHK("init order", INIT_SEQ, hist)
      `CHK("dll reset", ~skip, dll_seen)
    end
  endtask
  // held until the answer shows; one edge passes before it rises
  task automatic issue(input ddrci_cmd_t c, input logic [31:0] a);
    int i;
    @(negedge mclk_in);
    req_cmd_in = c;
    req_addr_in = a;
    req_write_in = (c == DDRCI_CMD_WR);
    req_valid_in = 1'b1;
    i = 0;
    do begin
      @(negedge mclk_in);
      i++;
    end while (req_ready_out !== 1'b1 && i < 50);
    req_valid_in = 1'b0;
    `CHK("ready", 1'b1, req_ready_out)
    if (req_ready_out !== 1'b1) finish_test();
  endtask
  task automatic access_map();
    logic [31:0] a;
    for (int k = 0; k < 4; k++) begin
      a = {k[7:0], 24'h123456};
      cs_auto_precharge_enable_in = 4'b0010;
      issue(DDRCI_CMD_ACT, a);
      `CHK("act cs_n", ~(4'h1 << k), mem_chip_select_n_out)
      `CHK("act row", 16'h0234, mem_addr_out)
      issue(k[0] ? DDRCI_CMD_WR : DDRCI_CMD_RD, a);
      `CHK("rw cs_n", ~(4'h1 << k), mem_chip_select_n_out)
      `CHK("rw col", {5'h00, k == 1, 10'h056}, mem_addr_out)
    end
    // zero interval closes the page even without per-cs enable
    burst_to_precharge_interval_in = 5'h00;
    cs_auto_precharge_enable_in = 4'h0;
    issue(DDRCI_CMD_ACT, 32'h02000100);
    issue(DDRCI_CMD_RD, 32'h02000100);
    `CHK("burst_to_precharge_interval ap", 16'h0400, mem_addr_out)
    burst_to_precharge_interval_in = 5'h08;
  endtask
  task automatic spacing(input logic tt);
    int n;
    two_cycle_command_timing_in = tt;
    issue(DDRCI_CMD_ACT, 32'h03000100);
    n = 1;
    @(negedge mclk_in);
    if (tt) begin
      `CHK("2t hold", DDRCI_CMD_ACT, mem_cmd_out)
    end else begin
      `CHK("1t release", DDRCI_CMD_NOP, mem_cmd_out)
    end
    // same activate again, raised one edge after the drop
    req_valid_in = 1'b1;
    do begin
      @(negedge mclk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 50);
    req_valid_in = 1'b0;
    // activate spacing max(6,4) plus the issuing cycle
    `CHK("act gap", 7, n)
    if (req_ready_out !== 1'b1) finish_test();
    two_cycle_command_timing_in = 1'b0;
    repeat (10) @(negedge mclk_in);
  endtask
  task automatic unmapped();
    logic hit;
    hit = 1'b0;
    req_addr_in = 32'h10000000;
    req_cmd_in = DDRCI_CMD_ACT;
    req_valid_in = 1'b1;
    repeat (20) begin
      @(negedge mclk_in);
      if (req_ready_out !== 1'b0 || mem_cmd_out !== DDRCI_CMD_NOP) hit = 1'b1;
    end
    req_valid_in = 1'b0;
    @(negedge mclk_in);
    `CHK("unmapped", 1'b0, hit)
  endtask
  // ==========================================
  // sequence
  initial begin
    init_run(1'b0, 1'b0, 5'h03);
    access_map();
    spacing(1'b0);
    spacing(1'b1);
    unmapped();
    init_run(1'b1, 1'b0, 5'h02);
    init_run(1'b0, 1'b1, 5'h03);
    finish_test();
  end
endmodule
